// [rtl/lpt_tx.v]
// led pulse-width serial transmitter top
// assumes pixel words arrive synchronous to mclk; div set by software
`timescale 1ns/10ps
`include "lpt_defines.vh"
module lpt_tx #(
   parameter SHORT_HIGH_CYCLES = `LPT_T1_DEF,
   parameter EXTENDED_HIGH_CYCLES = `LPT_T2_DEF,
   parameter LOW_PHASE_CYCLES = `LPT_T3_DEF,
   parameter FIFO_DEPTH = `LPT_FIFO_DEPTH
)(
   // system
   input wire mclk,
   input wire resetn,
   // configuration
   input wire enable,
   input wire four_colour,
   input wire [`LPT_DIV_W-1:0] div_int,
   input wire [`LPT_FRAC_W-1:0] div_frac,
   // pixel stream
   input wire pix_valid,
   output wire pix_ready,
   input wire [`LPT_WORD_W-1:0] pix_data,
   // status
   output reg stalled,
   output reg busy,
   // led line
   output reg led_out,
   output reg led_oe
);
   localparam ST_FETCH = 2'd0;
   localparam ST_TEST = 2'd1;
   localparam ST_ONE = 2'd2;
   localparam ST_ZERO = 2'd3;
   localparam CW = 5;
   localparam [CW-1:0] T1_LAST = SHORT_HIGH_CYCLES - 1;
   localparam [CW-1:0] T2_LAST = EXTENDED_HIGH_CYCLES - 1;
   localparam [CW-1:0] T3_LAST = LOW_PHASE_CYCLES - 1;

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [CW-1:0] delay_reg;
   reg [CW-1:0] delay_next;
   reg [`LPT_WORD_W-1:0] output_shift_register_reg;
   reg [`LPT_WORD_W-1:0] osr_next;
   reg [5:0] shifted_reg;
   reg [5:0] shifted_next;
   reg bit_reg;
   reg bit_next;
   reg line_next;
   reg stall_next;
   reg fifo_pop;
   wire tick;
   wire fifo_valid;
   wire [`LPT_WORD_W-1:0] fifo_data;
   wire [5:0] thresh;
   wire osr_empty;
   wire refill_now;
   wire data_ok;
   wire step;
   wire fetch_go;

   // the fifo stands between the supplier and the shift register
   lpt_fifo #(
      .WIDTH(`LPT_WORD_W),
      .DEPTH(FIFO_DEPTH),
      .AW(3)
   ) u_fifo (
      .mclk(mclk),
      .resetn(resetn),
      .in_valid(pix_valid),
      .in_ready(pix_ready),
      .in_data(pix_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data),
      .flush(1'b0)
   );

   // software programs div = sys_hz / (rate * (t1+t2+t3))
   lpt_clkdiv u_div (
      .mclk(mclk),
      .resetn(resetn),
      .run(enable),
      .div_int(div_int),
      .div_frac(div_frac),
      .tick(tick)
   );

   assign thresh = four_colour ? `LPT_THRESH_RGBW : `LPT_THRESH_RGB;
   assign osr_empty = (shifted_reg >= thresh);
   // background refill whenever the register is exhausted, outside ticks too
   assign refill_now = enable && osr_empty && fifo_valid;
   // a bit is available if the register still holds one or a refill lands now
   assign data_ok = !osr_empty || fifo_valid;
   // a step executes only on a tick whose programmed delay has run out
   assign step = enable && tick && (delay_reg == {CW{1'b0}});
   assign fetch_go = step && (state_reg == ST_FETCH) && data_ok;

   // sequencer: which step runs next and how long it lasts
   always @*
   begin
      state_next = state_reg;
      delay_next = delay_reg;
      if (!enable)
      begin
         state_next = ST_FETCH;
         delay_next = {CW{1'b0}};
      end
      else if (tick && (delay_reg != {CW{1'b0}}))
      begin
         delay_next = delay_reg - 1'b1;
      end
      else if (step)
      begin
         case (state_reg)
            ST_FETCH:
            begin
               // no data: stay here and retry on the next tick
               if (data_ok)
               begin
                  delay_next = T3_LAST;
                  state_next = ST_TEST;
               end
            end
            ST_TEST:
            begin
               delay_next = T1_LAST;
               state_next = bit_reg ? ST_ONE : ST_ZERO;
            end
            ST_ONE:
            begin
               delay_next = T2_LAST;
               state_next = ST_FETCH;
            end
            ST_ZERO:
            begin
               delay_next = T2_LAST;
               state_next = ST_FETCH;
            end
            default:
            begin
               delay_next = {CW{1'b0}};
               state_next = ST_FETCH;
            end
         endcase
      end
   end

   // line drive: each step sets the level it holds for its whole length
   always @*
   begin
      line_next = led_out;
      if (!enable)
      begin
         line_next = 1'b0;
      end
      else if (step)
      begin
         case (state_reg)
            ST_FETCH:
            begin
               // low even when the fetch stalls, so idle reads as latch
               line_next = 1'b0;
            end
            ST_TEST:
            begin
               line_next = 1'b1;
            end
            ST_ONE:
            begin
               line_next = 1'b1;
            end
            ST_ZERO:
            begin
               line_next = 1'b0;
            end
            default:
            begin
               line_next = 1'b0;
            end
         endcase
      end
   end

   // stall flag follows every fetch attempt
   // a disable clears it; it returns at the first fetch step without data
   always @*
   begin
      stall_next = stalled;
      if (!enable)
      begin
         stall_next = 1'b0;
      end
      else if (step && (state_reg == ST_FETCH))
      begin
         stall_next = !data_ok;
      end
   end

   // shift path: refill and bit fetch share the register
   always @*
   begin
      osr_next = output_shift_register_reg;
      shifted_next = shifted_reg;
      bit_next = bit_reg;
      fifo_pop = 1'b0;
      if (!enable)
      begin
         // a restart begins on a fresh word, never on a stale remainder
         shifted_next = `LPT_THRESH_RGBW;
      end
      else if (fetch_go)
      begin
         // take msb from a freshly loaded word if refilling now
         fifo_pop = refill_now;
         if (refill_now)
         begin
            bit_next = fifo_data[`LPT_WORD_W-1];
            osr_next = {fifo_data[`LPT_WORD_W-2:0], 1'b0};
            shifted_next = 6'h01;
         end
         else
         begin
            bit_next = output_shift_register_reg[`LPT_WORD_W-1];
            osr_next = {output_shift_register_reg[`LPT_WORD_W-2:0], 1'b0};
            shifted_next = shifted_reg + 6'h01;
         end
      end
      else if (refill_now)
      begin
         osr_next = fifo_data;
         shifted_next = 6'h00;
         fifo_pop = 1'b1;
      end
   end

   // sequencer registers
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg <= ST_FETCH;
         delay_reg <= {CW{1'b0}};
      end
      else
      begin
         state_reg <= state_next;
         delay_reg <= delay_next;
      end
   end

   // shift path registers
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         output_shift_register_reg <= {`LPT_WORD_W{1'b0}};
         shifted_reg <= `LPT_THRESH_RGBW; // starts exhausted
         bit_reg <= 1'b0;
      end
      else
      begin
         output_shift_register_reg <= osr_next;
         shifted_reg <= shifted_next;
         bit_reg <= bit_next;
      end
   end

   // every top-level output except pix_ready (the fifo's in_ready flop) leaves straight from one of these flops
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         led_out <= 1'b0;
         led_oe <= 1'b0;
         stalled <= 1'b0;
         busy <= 1'b0;
      end
      else
      begin
         led_out <= line_next;
         led_oe <= enable;
         stalled <= stall_next;
         busy <= enable && !stall_next;
      end
   end
endmodule // lpt_tx

// [rtl/lpt_defines.vh]
// constants for the led pulse-width serial transmitter
// assumes inclusion by bare name from the rtl modules
`ifndef LPT_DEFINES_VH
`define LPT_DEFINES_VH
`define LPT_T1_DEF 2
`define LPT_T2_DEF 5
`define LPT_T3_DEF 3
`define LPT_WORD_W 32
`define LPT_THRESH_RGB 6'h18
`define LPT_THRESH_RGBW 6'h20
`define LPT_FIFO_DEPTH 8
`define LPT_DIV_W 16
`define LPT_DIV_RST 16'h0001
`define LPT_FRAC_W 8
`define LPT_SYS_HZ 20000000
`endif

// [rtl/lpt_fifo.v]
// synchronous word fifo with valid/ready on both sides
// assumes one clock, asynchronous active-low reset
`timescale 1ns/10ps
module lpt_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = 8,
   parameter AW = 3
)(
   // system
   input wire mclk,
   input wire resetn,
   // fill side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // drain side
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data,
   // state
   input wire flush
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   reg in_ready_reg;
   wire do_wr;
   wire do_rd;
   // registered so the supplier sees a flop, not a compare
   assign in_ready = in_ready_reg;
   assign out_valid = (count_reg != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr_reg];
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;
   always @(posedge mclk)
   begin
      if (do_wr)
         mem[wr_ptr_reg] <= in_data;
   end
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
         in_ready_reg <= 1'b1;
      end
      else if (flush)
      begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
         in_ready_reg <= 1'b1;
      end
      else
      begin
         if (do_wr)
            wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
         if (do_rd)
            rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
         if (do_wr && !do_rd)
         begin
            count_reg <= count_reg + 1'b1;
            in_ready_reg <= (count_reg != DEPTH[AW:0] - 1'b1);
         end
         else if (do_rd && !do_wr)
         begin
            count_reg <= count_reg - 1'b1;
            in_ready_reg <= 1'b1;
         end
      end
   end
endmodule // lpt_fifo

// [rtl/lpt_clkdiv.v]
// fractional divider making one execution tick per divided period
// assumes div_int >= 1; frac accumulates in 1/256 steps
`timescale 1ns/10ps
`include "lpt_defines.vh"
module lpt_clkdiv (
   // system
   input wire mclk,
   input wire resetn,
   // control
   input wire run,
   input wire [`LPT_DIV_W-1:0] div_int,
   input wire [`LPT_FRAC_W-1:0] div_frac,
   // tick
   output reg tick
);
   reg [`LPT_DIV_W-1:0] cnt_reg;
   reg [`LPT_FRAC_W-1:0] acc_reg;
   wire [`LPT_FRAC_W:0] acc_sum;
   wire [`LPT_DIV_W-1:0] period;
   assign acc_sum = {1'b0, acc_reg} + {1'b0, div_frac};
   // carry of the fraction stretches this period by one clock
   assign period = div_int + {{(`LPT_DIV_W-1){1'b0}}, acc_sum[`LPT_FRAC_W]};
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_reg <= {`LPT_DIV_W{1'b0}};
         acc_reg <= {`LPT_FRAC_W{1'b0}};
         tick <= 1'b0;
      end
      else if (!run)
      begin
         cnt_reg <= {`LPT_DIV_W{1'b0}};
         acc_reg <= {`LPT_FRAC_W{1'b0}};
         tick <= 1'b0;
      end
      else if (cnt_reg + 1'b1 >= period)
      begin
         cnt_reg <= {`LPT_DIV_W{1'b0}};
         acc_reg <= acc_sum[`LPT_FRAC_W-1:0];
         tick <= 1'b1;
      end
      else
      begin
         cnt_reg <= cnt_reg + 1'b1;
         tick <= 1'b0;
      end
   end
endmodule // lpt_clkdiv

// [verif/lpt_led_rx.sv]
// led chain input model: turns pulse widths back into bits
// assumes one execution tick per mclk when bits are decoded
`timescale 1ns/10ps
module lpt_led_rx (
   // line
   input wire mclk,
   input wire led_out,
   // decoded
   output logic [31:0] rx_word = 32'h00000000,
   output logic [15:0] rx_bits = 16'h0000,
   output logic [15:0] rx_gap = 16'h0000
);
   logic [15:0] hi_cnt = 16'h0000;
   logic [15:0] gap_cnt = 16'h0000;
   logic last = 1'b0;
   always @(posedge mclk)
   begin
      hi_cnt <= led_out ? hi_cnt + 16'h0001 : 16'h0000;
      gap_cnt <= (led_out && !last) ? 16'h0001 : gap_cnt + 16'h0001;
      if (led_out && !last)
         rx_gap <= gap_cnt;
      if (!led_out && last)
      begin
         // threshold sits between narrow and wide pulse
         rx_word <= {rx_word[30:0], hi_cnt > 16'h0004};
         rx_bits <= rx_bits + 16'h0001;
      end
      last <= led_out;
   end
endmodule // lpt_led_rx

// [verif/lpt_tx_properties.sv]
// port checker for the led pulse-width transmitter
// assumes one clock; bound to lpt_tx at the foot
`timescale 1ns/10ps
module lpt_tx_chk #(
   parameter SHORT_HIGH_CYCLES = 2,
   parameter EXTENDED_HIGH_CYCLES = 5,
   parameter LOW_PHASE_CYCLES = 3
)(
   // inputs
   input wire mclk,
   input wire resetn,
   input wire enable,
   input wire [15:0] div_int,
   input wire [7:0] div_frac,
   input wire pix_valid,
   // outputs
   input wire pix_ready,
   input wire stalled,
   input wire busy,
   input wire led_out,
   input wire led_oe
);
   reg [7:0] hi_len;
   reg [7:0] per_len;
   reg idle_seen;
   wire div1 = div_int == 16'h0001 && div_frac == 8'h00;
   wire rise = led_out && hi_len == 8'h00;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         hi_len <= 8'h00;
         per_len <= 8'h00;
         idle_seen <= 1'b1;
      end
      else
      begin
         hi_len <= led_out ? hi_len + 8'h01 : 8'h00;
         per_len <= rise ? 8'h01 : per_len + 8'h01;
         // stalls and rate changes stretch a period legally
         idle_seen <= rise ? 1'b0 : idle_seen | stalled | !enable | !div1;
      end
   end
   property p_high_width;
      $fell(led_out) && div1 |-> hi_len == SHORT_HIGH_CYCLES
         || hi_len == SHORT_HIGH_CYCLES + EXTENDED_HIGH_CYCLES;
   endproperty
   a_high_width: assert property (p_high_width) else $error("pulse width");
   property p_period;
      rise && !idle_seen |-> per_len == SHORT_HIGH_CYCLES + EXTENDED_HIGH_CYCLES
         + LOW_PHASE_CYCLES;
   endproperty
   a_period: assert property (p_period) else $error("bit period");
   property p_stall_low;
      $past(stalled) |-> !led_out;
   endproperty
   a_stall_low: assert property (p_stall_low) else $error("line high in stall");
   property p_oe;
      led_oe == $past(enable);
   endproperty
   a_oe: assert property (p_oe) else $error("drive enable");
   property p_start_low;
      $rose(enable) |-> !led_out [*2];
   endproperty
   a_start_low: assert property (p_start_low) else $error("start not low");
   property p_retry;
      enable && stalled && pix_valid && pix_ready && div1 |-> ##[1:8] !stalled;
   endproperty
   a_retry: assert property (p_retry) else $error("stall not left");
   property p_busy;
      stalled && $past(stalled) |-> !busy;
   endproperty
   a_busy: assert property (p_busy) else $error("busy in stall");
   property p_ready;
      $fell(pix_ready) |-> $past(pix_valid);
   endproperty
   a_ready: assert property (p_ready) else $error("ready fell alone");
endmodule // lpt_tx_chk
bind lpt_tx lpt_tx_chk #(.SHORT_HIGH_CYCLES(SHORT_HIGH_CYCLES),
   .EXTENDED_HIGH_CYCLES(EXTENDED_HIGH_CYCLES), .LOW_PHASE_CYCLES(LOW_PHASE_CYCLES))
   i_lpt_tx_chk (.mclk, .resetn, .enable, .div_int, .div_frac, .pix_valid, .pix_ready,
   .stalled, .busy, .led_out, .led_oe);

// [verif/testbench.sv]
// self-checking bench for the led pulse-width transmitter
// assumes the led chain model and the checker are compiled first
`timescale 1ns/10ps
module testbench;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic enable = 1'b0;
   logic four_colour = 1'b0;
   logic [15:0] div_int = 16'h0001;
   logic [7:0] div_frac = 8'h00;
   logic pix_valid = 1'b0;
   logic [31:0] pix_data = 32'h00000000;
   wire pix_ready, stalled, busy, led_out, led_oe;
   wire [31:0] rx_word;
   wire [15:0] rx_bits, rx_gap;
   int failures = 0;
   int check_count = 0;
   int cyc = 0;
   always #25 mclk = ~mclk;
   lpt_tx i_lpt_tx (.mclk, .resetn, .enable, .four_colour, .div_int, .div_frac, .pix_valid,
      .pix_ready, .pix_data, .stalled, .busy, .led_out, .led_oe);
   lpt_led_rx i_lpt_led_rx (.mclk, .led_out, .rx_word, .rx_bits, .rx_gap);
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // valid stays up so back-to-back words need no gap
   task push(input logic [31:0] w);
      pix_data <= w;
      pix_valid <= 1'b1;
      @(posedge mclk);
      while (!pix_ready)
         @(posedge mclk);
   endtask
   task drain;
      pix_valid <= 1'b0;
      repeat (20) @(posedge mclk);
      while (!stalled)
         @(posedge mclk);
      // let the line model take in the final falling edge
      repeat (2) @(posedge mclk);
   endtask
   task results;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         failures++;
         results;
      end
   end
   initial
   begin
      repeat (16) @(posedge mclk);
      check("reset outs", {led_oe, led_out, pix_ready}, 32'h1);
      resetn <= 1'b1;
      @(posedge mclk);
      enable <= 1'b1;
      repeat (8) @(posedge mclk);
      check("empty stall", {stalled, led_out, busy}, 32'h4);
      push(32'ha5c30f00);
      drain;
      check("rgb bits", rx_bits, 32'h18);
      check("rgb word", rx_word[23:0], 32'ha5c30f);
      check("period", rx_gap, 32'ha);
      // a restart with the new threshold starts on a fresh word
      enable <= 1'b0;
      four_colour <= 1'b1;
      @(posedge mclk);
      enable <= 1'b1;
      push(32'h80000001);
      drain;
      check("rgbw bits", rx_bits, 32'h38);
      check("rgbw word", rx_word, 32'h80000001);
      enable <= 1'b0;
      four_colour <= 1'b0;
      for (int i = 0; i < 8; i++)
         push({i[7:0], 24'h5a5a00});
      pix_valid <= 1'b0;
      @(posedge mclk);
      check("full", pix_ready, 32'h0);
      enable <= 1'b1;
      push(32'h085a5a00);
      drain;
      check("burst bits", rx_bits, 32'h110);
      check("burst word", rx_word[23:0], 32'h085a5a);
      check("refill gap", rx_gap, 32'ha);
      div_int <= 16'h0003;
      push(32'hff000000);
      pix_valid <= 1'b0;
      repeat (4) @(posedge mclk);
      check("running", {busy, stalled, led_oe}, 32'h5);
      drain;
      check("slow bits", rx_bits, 32'h128);
      check("slow period", rx_gap, 32'h1e);
      // half-step fraction: ticks alternate 2 and 3 clocks, 25 per bit
      div_int <= 16'h0002;
      div_frac <= 8'h80;
      push(32'hff000000);
      drain;
      check("frac bits", rx_bits, 32'h140);
      check("frac period", rx_gap, 32'h19);
      results;
   end
endmodule // testbench
